// *** pkg/qfp_pkg.sv ***
// Package for the quad-phase fetch/execute pipeline: phases, widths, vectors and carrier structs.
// Assumes a single 20 MHz clock domain; program memory answers combinationally within one phase.
package qfp_pkg;
    localparam int PC_WIDTH = 13;
    localparam int INSTR_WIDTH = 14;
    localparam int DATA_WIDTH = 8;
    localparam int DADDR_WIDTH = 7;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam logic [13:0] NOP_WORD = 14'h0000;
    localparam logic [1:0] PHASE_ONE_IDX = 2'h0;
    localparam logic [1:0] PHASE_TWO_IDX = 2'h1;
    localparam logic [1:0] PHASE_THREE_IDX = 2'h2;
    localparam logic [1:0] PHASE_FOUR_IDX = 2'h3;
    localparam logic [1:0] QUARTER_CLOCK_OUT_HIGH_IDX = 2'h2;
    // Opcode fields of the executed word.
    localparam logic [2:0] OPC_JUMP = 3'h5;
    localparam logic [2:0] OPC_CALL = 3'h4;
    localparam logic [5:0] OPC_MOVWF = 6'h00;
    localparam logic [5:0] OPC_ADDWF = 6'h07;
    localparam logic [5:0] OPC_MOVLW = 6'h30;
    localparam int OPC_HI = 13;
    localparam int OPC6_LO = 8;
    localparam int OPC3_LO = 11;
    localparam int DEST_BIT = 7;

    typedef enum logic [1:0] {QFP_PH1, QFP_PH2, QFP_PH3, QFP_PH4} qfp_phase_t;

    typedef struct packed {
        logic phaseOne;
        logic phaseTwo;
        logic phaseThree;
        logic phaseFour;
    } qfp_phases_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [DADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
    } qfp_dmem_req_t;
endpackage : qfp_pkg

// *** rtl/qfp_phase_gen.sv ***
// Phase generator: divides ref_clk by four into one-cycle phase enables and a quarter-rate clock.
// Assumes a synchronised, active-high reset hold input from the top.
`timescale 1ns/1ps
module qfp_phase_gen
(
    input wire logic ref_clk, // System clock.
    input wire logic rst, // Synchronous reset.
    input wire logic holdPhase, // Held master clear.
    output qfp_pkg::qfp_phases_t phases, // One-hot phase enables.
    output logic quarterClk // Quarter-rate clock.
);
    import qfp_pkg::*;

    qfp_phase_t phase_q;
    qfp_phase_t phase_d;
    logic clk_q;
    logic clk_d;

    // Next phase; a hold parks the generator so phase_one comes next.
    always_comb
    begin
        phase_d = phase_q.next();
        if (holdPhase)
        begin
            phase_d = QFP_PH4;
        end
        clk_d = (phase_d == QFP_PH1) || (phase_d == QFP_PH2);
        if (holdPhase)
        begin
            clk_d = 1'b0;
        end
    end

    // Registers only.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            phase_q <= QFP_PH4;
            clk_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            clk_q <= clk_d;
        end
    end

    // Enables are decoded from the phase register; they never overlap.
    always_comb
    begin
        phases.phaseOne = (phase_q == QFP_PH1) && !holdPhase;
        phases.phaseTwo = (phase_q == QFP_PH2) && !holdPhase;
        phases.phaseThree = (phase_q == QFP_PH3) && !holdPhase;
        phases.phaseFour = (phase_q == QFP_PH4) && !holdPhase;
    end
    assign quarterClk = clk_q;
endmodule : qfp_phase_gen

// *** rtl/qfp_pipeline.sv ***
// Quad-phase two-stage fetch/execute pipeline core.
// Assumes program memory returns progData combinationally for progAddr and data memory answers dmemRdata
// combinationally for the address presented; master_clear_n is an asynchronous pin.
`timescale 1ns/1ps
module qfp_pipeline
(
    input wire logic ref_clk, // 20 MHz system clock.
    input wire logic rst, // Synchronous power-on reset.
    input wire logic master_clear_n, // Active-low master clear pin.
    input wire logic rcMode, // RC oscillator mode select.
    input wire logic irqRequest, // Interrupt request level.
    input wire logic [qfp_pkg::INSTR_WIDTH-1:0] progData, // Program memory word.
    input wire logic [qfp_pkg::DATA_WIDTH-1:0] dmemRdata, // Data memory read data.
    output logic [qfp_pkg::PC_WIDTH-1:0] progAddr, // Program memory address.
    output qfp_pkg::qfp_dmem_req_t dmemReq, // Data memory request.
    output qfp_pkg::qfp_phases_t phaseOut, // Registered phase enables.
    output logic quarter_clock_out, // Instruction-rate clock in RC mode.
    output logic [qfp_pkg::DATA_WIDTH-1:0] accOut, // Working register.
    output logic zeroFlag, // Zero status flag.
    output logic [qfp_pkg::INSTR_WIDTH-1:0] execWord, // Word in execute.
    output logic execValid, // Execute slot holds a real instruction.
    output logic retirePulse // One pulse per completed instruction.
);
    import qfp_pkg::*;

    logic mclrLevel;
    logic holdReset;
    qfp_phases_t ph;
    logic quarterClk;

    // Master clear passes a three-flop synchroniser before it may reset the core.
    qfp_sync3 u_master_clear_n_sync
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .pinIn(master_clear_n),
        .levelOut(mclrLevel)
    );

    assign holdReset = !mclrLevel;

    qfp_phase_gen u_phase_gen
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .holdPhase(holdReset),
        .phases(ph),
        .quarterClk(quarterClk)
    );

    logic [PC_WIDTH-1:0] pc_q, pc_d;
    logic [PC_WIDTH-1:0] fetchAddr_q, fetchAddr_d;
    logic [INSTR_WIDTH-1:0] fetchReg_q, fetchReg_d;
    logic fetchValid_q, fetchValid_d;
    logic [INSTR_WIDTH-1:0] ir_q, ir_d;
    logic irValid_q, irValid_d;
    logic flush_q, flush_d;
    logic [PC_WIDTH-1:0] target_q, target_d;
    logic irqPend_q, irqPend_d;
    logic [DATA_WIDTH-1:0] operand_q, operand_d;
    logic [DATA_WIDTH-1:0] acc_q, acc_d;
    logic zero_q, zero_d;
    qfp_dmem_req_t dreq_q, dreq_d;
    qfp_phases_t phaseOut_q;
    logic qclk_q, qclk_d;
    logic retire_q, retire_d;

    logic [2:0] opc3;
    logic [5:0] opc6;
    logic isBranch;
    logic destFile;
    logic [DATA_WIDTH-1:0] result;

    // Decode fields of the word in execute.
    always_comb
    begin
        opc3 = ir_q[OPC_HI:OPC3_LO];
        opc6 = ir_q[OPC_HI:OPC6_LO];
        isBranch = irValid_q && ((opc3 == OPC_JUMP) || (opc3 == OPC_CALL));
        destFile = ir_q[DEST_BIT];
        result = 8'h00;
        if (opc6 == OPC_ADDWF)
        begin
            result = acc_q + operand_q;
        end
        else if (opc6 == OPC_MOVWF)
        begin
            result = acc_q;
        end
        else if (opc6[5:4] == OPC_MOVLW[5:4])
        begin
            result = ir_q[7:0];
        end
        else
        begin
            result = operand_q;
        end
    end

    // Fetch and execute stages advance on phase enables; both stages run in parallel each cycle.
    always_comb
    begin
        pc_d = pc_q;
        fetchAddr_d = fetchAddr_q;
        fetchReg_d = fetchReg_q;
        fetchValid_d = fetchValid_q;
        ir_d = ir_q;
        irValid_d = irValid_q;
        flush_d = flush_q;
        target_d = target_q;
        irqPend_d = irqPend_q || irqRequest;
        operand_d = operand_q;
        acc_d = acc_q;
        zero_d = zero_q;
        dreq_d = dreq_q;
        dreq_d.read = 1'b0;
        dreq_d.write = 1'b0;
        retire_d = 1'b0;
        if (holdReset)
        begin
            pc_d = RESET_VECTOR;
            fetchAddr_d = RESET_VECTOR;
            fetchValid_d = 1'b0;
            irValid_d = 1'b0;
            flush_d = 1'b0;
            irqPend_d = 1'b0;
        end
        else if (ph.phaseOne)
        begin
            // Fetch address is latched and the counter steps; a branch or interrupt redirects it.
            if (flush_q)
            begin
                fetchAddr_d = target_q;
                pc_d = target_q + 13'h0001;
            end
            else if (irqPend_q)
            begin
                fetchAddr_d = IRQ_VECTOR;
                pc_d = IRQ_VECTOR + 13'h0001;
                irqPend_d = irqRequest;
            end
            else
            begin
                fetchAddr_d = pc_q;
                pc_d = pc_q + 13'h0001;
            end
            // The previously fetched word enters the decoder; a flush voids it.
            ir_d = fetchReg_q;
            irValid_d = fetchValid_q && !flush_q;
            flush_d = 1'b0;
        end
        else if (ph.phaseTwo)
        begin
            dreq_d.addr = ir_q[DADDR_WIDTH-1:0];
            dreq_d.read = irValid_q;
            if (isBranch)
            begin
                target_d = {2'h0, ir_q[10:0]};
                flush_d = 1'b1;
            end
        end
        else if (ph.phaseThree)
        begin
            operand_d = dmemRdata;
        end
        else if (ph.phaseFour)
        begin
            fetchReg_d = progData;
            fetchValid_d = 1'b1;
            if (irValid_q && !isBranch)
            begin
                if (destFile && (opc6 != OPC_MOVLW))
                begin
                    dreq_d.write = 1'b1;
                    dreq_d.wdata = result;
                end
                else
                begin
                    acc_d = result;
                end
                zero_d = (result == 8'h00);
            end
            retire_d = irValid_q;
        end
    end

    // Quarter clock is only driven in RC mode; otherwise the pin rests low.
    always_comb
    begin
        qclk_d = rcMode && quarterClk;
    end

    // Registers only.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pc_q <= RESET_VECTOR;
            fetchAddr_q <= RESET_VECTOR;
            fetchReg_q <= NOP_WORD;
            fetchValid_q <= 1'b0;
            ir_q <= NOP_WORD;
            irValid_q <= 1'b0;
            flush_q <= 1'b0;
            target_q <= RESET_VECTOR;
            irqPend_q <= 1'b0;
            operand_q <= 8'h00;
            acc_q <= 8'h00;
            zero_q <= 1'b0;
            dreq_q <= '0;
            phaseOut_q <= '0;
            qclk_q <= 1'b0;
            retire_q <= 1'b0;
        end
        else
        begin
            pc_q <= pc_d;
            fetchAddr_q <= fetchAddr_d;
            fetchReg_q <= fetchReg_d;
            fetchValid_q <= fetchValid_d;
            ir_q <= ir_d;
            irValid_q <= irValid_d;
            flush_q <= flush_d;
            target_q <= target_d;
            irqPend_q <= irqPend_d;
            operand_q <= operand_d;
            acc_q <= acc_d;
            zero_q <= zero_d;
            dreq_q <= dreq_d;
            phaseOut_q <= ph;
            qclk_q <= qclk_d;
            retire_q <= retire_d;
        end
    end

    assign progAddr = fetchAddr_q;
    assign dmemReq = dreq_q;
    assign phaseOut = phaseOut_q;
    assign quarter_clock_out = qclk_q;
    assign accOut = acc_q;
    assign zeroFlag = zero_q;
    assign execWord = ir_q;
    assign execValid = irValid_q;
    assign retirePulse = retire_q;
endmodule : qfp_pipeline

// *** rtl/qfp_sync3.sv ***
// Three-flop input synchroniser with agreement of the last two stages.
// Assumes an asynchronous pin level; the output changes only when stages two and three agree.
`timescale 1ns/1ps
module qfp_sync3
(
    input wire logic ref_clk, // System clock.
    input wire logic rst, // Synchronous reset.
    input wire logic pinIn, // Raw pin level.
    output logic levelOut // Filtered level.
);
    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic level_q;
    logic level_d;

    // The first stage feeds only the second, as any synchroniser must.
    always_comb
    begin
        stage_d = {stage_q[1:0], pinIn};
        level_d = level_q;
        if (stage_q[1] == stage_q[2])
        begin
            level_d = stage_q[2];
        end
    end

    // Reset value is high so the part does not sit in reset after rst drops.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            stage_q <= 3'h7;
            level_q <= 1'b1;
        end
        else
        begin
            stage_q <= stage_d;
            level_q <= level_d;
        end
    end
    assign levelOut = level_q;
endmodule : qfp_sync3

// *** verification/qfp_pipeline_asserts.sv ***
// Checker of the pipeline core: phase order, fetch step, data phases, retire spacing, clear.
// Assumes only the core's ports; bound to every core instance below.
`timescale 1ns/1ps
module qfp_pipeline_asserts
(
    input wire logic ref_clk, // Clock.
    input wire logic rst, // Reset.
    input wire logic master_clear_n, // Clear pin.
    input wire logic rcMode, // RC mode.
    input wire logic [qfp_pkg::PC_WIDTH-1:0] progAddr, // Fetch address.
    input wire qfp_pkg::qfp_dmem_req_t dmemReq, // Data request.
    input wire qfp_pkg::qfp_phases_t phaseOut, // Phases.
    input wire logic quarter_clock_out, // Quarter clock.
    input wire logic execValid, // Valid slot.
    input wire logic retirePulse // Retire.
);
    import qfp_pkg::*;
    logic [7:0] clrHist_q;
    logic [7:0] clrHist_d;
    logic quiet;
    // Phases break off at an arbitrary point on any clear, so timing checks wait it out.
    always_comb
    begin
        clrHist_d = {clrHist_q[6:0], rst | ~master_clear_n};
    end
    always_ff @(posedge ref_clk)
    begin
        clrHist_q <= clrHist_d;
    end
    assign quiet = (clrHist_q == 8'h00);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_onehot; $onehot0(phaseOut); endproperty
    a_onehot: assert property (p_onehot) else $error("phases overlap");
    property p_order; quiet && phaseOut.phaseOne |=> phaseOut.phaseTwo ##1 phaseOut.phaseThree
        ##1 phaseOut.phaseFour; endproperty
    a_order: assert property (p_order) else $error("phase order");
    property p_fetch; quiet && !$stable(progAddr) |-> phaseOut.phaseOne; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch step off phase one");
    property p_read; dmemReq.read |-> phaseOut.phaseTwo; endproperty
    a_read: assert property (p_read) else $error("read off phase two");
    property p_write; dmemReq.write |-> phaseOut.phaseFour && retirePulse; endproperty
    a_write: assert property (p_write) else $error("stray write");
    property p_retire; retirePulse |-> phaseOut.phaseFour && execValid ##1 !retirePulse [*3]; endproperty
    a_retire: assert property (p_retire) else $error("retire spacing");
    property p_quarter; quiet && rcMode && $rose(quarter_clock_out) |=> quarter_clock_out
        ##1 !quarter_clock_out ##1 !quarter_clock_out; endproperty
    a_quarter: assert property (p_quarter) else $error("quarter clock shape");
    property p_clear; clrHist_q == 8'hFF |-> !execValid && !retirePulse; endproperty
    a_clear: assert property (p_clear) else $error("valid during clear");
endmodule : qfp_pipeline_asserts
bind qfp_pipeline qfp_pipeline_asserts qfp_pipeline_asserts_i (.ref_clk, .rst, .master_clear_n, .rcMode,
    .progAddr, .dmemReq, .phaseOut, .quarter_clock_out, .execValid, .retirePulse);

// *** verification/qfp_pipeline_test.sv ***
// Testbench of the pipeline core: loop program, random operands, branch, interrupt, master clear.
// Assumes qfp_prog_rom as program memory and the bound checker.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    checksDone++; \
    if ((got) !== (ex)) \
    begin \
        mismatches++; \
        $display("ERROR %s exp %0h got %0h", nm, ex, got); \
    end
module qfp_pipeline_test;
    import qfp_pkg::*;
    typedef struct packed {logic [6:0] a; logic [7:0] d; logic zc; logic z; logic [7:0] gap;} qfp_note_t;
    logic ref_clk = 1'b0;
    logic rst, masterClearN, rcMode, irqRequest, watch, hit;
    logic [INSTR_WIDTH-1:0] progData, execWord;
    logic [DATA_WIDTH-1:0] dmemRdata, accOut, sum;
    logic [PC_WIDTH-1:0] progAddr;
    qfp_dmem_req_t dmemReq;
    qfp_phases_t phaseOut;
    logic quarterClockOut, zeroFlag, execValid, retirePulse;
    logic [31:0] seed = 32'h4B063775;
    qfp_note_t notes[$];
    qfp_note_t note;
    int mismatches = 0, checksDone = 0, cyc = 0, lastW = 0;
    always #25 ref_clk = ~ref_clk;
    qfp_pipeline qfp_pipeline_i (.ref_clk(ref_clk), .rst(rst), .master_clear_n(masterClearN),
        .rcMode(rcMode), .irqRequest(irqRequest), .progData(progData), .dmemRdata(dmemRdata),
        .progAddr(progAddr), .dmemReq(dmemReq), .phaseOut(phaseOut), .quarter_clock_out(quarterClockOut),
        .accOut(accOut), .zeroFlag(zeroFlag), .execWord(execWord), .execValid(execValid),
        .retirePulse(retirePulse));
    qfp_prog_rom qfp_prog_rom_i (.progAddr(progAddr), .progData(progData));
    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsrNext
    task printVerdict;
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : printVerdict
    // Notes three writes per pass; gaps are 8 clocks straight, 12 over a jump, 16 over a jump and the literal load.
    task runLoops(input int n, input bit fresh);
        for (int i = 0; i < n; i++)
        begin
            sum = 8'h3C + dmemRdata;
            notes.push_back({7'h21, 8'h3C, 1'b0, 1'b0, (fresh && i == 0) ? 8'h00 : 8'h10});
            notes.push_back({7'h23, sum, 1'b1, sum == 8'h00, 8'h08});
            notes.push_back({7'h24, sum, 1'b1, sum == 8'h00, 8'h0C});
            hit = 1'b0;
            for (int k = 0; k < 80 && !hit; k++)
            begin
                @(posedge ref_clk);
                hit = dmemReq.write && dmemReq.addr == 7'h24;
            end
            `CHK("loop end", 1'b1, hit)
            seed = lfsrNext(seed);
            dmemRdata <= seed[7:0];
            // Let the new operand settle so the next expected sum is built from it.
            @(posedge ref_clk);
        end
    endtask : runLoops
    // Pairs each data write with the oldest note while watch is set.
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (!rst && dmemReq.write)
        begin
            lastW <= cyc;
            if (watch)
            begin
                `CHK("note queued", 1'b1, notes.size() != 0)
                note = notes.pop_front();
                `CHK("write addr", note.a, dmemReq.addr)
                `CHK("write data", note.d, dmemReq.wdata)
                `CHK("exec opcode", OPC_MOVWF, execWord[OPC_HI:OPC6_LO])
                if (note.zc)
                begin
                    `CHK("zero flag", note.z, zeroFlag)
                    `CHK("working reg", note.d, accOut)
                end
                if (note.gap != 8'h00)
                begin
                    `CHK("write gap", note.gap, 8'(cyc - lastW))
                end
            end
        end
    end
    // Main sequence; the first operand makes the sum zero.
    initial
    begin
        rst = 1'b1;
        masterClearN = 1'b1;
        rcMode = 1'b1;
        irqRequest = 1'b0;
        dmemRdata = 8'hC4;
        watch = 1'b1;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        runLoops(5, 1'b1);
        // The interrupt leaves the loop, so pairing pauses until after the clear.
        watch <= 1'b0;
        irqRequest <= 1'b1;
        hit = 1'b0;
        for (int k = 0; k < 40 && !hit; k++)
        begin
            @(posedge ref_clk);
            hit = progAddr === IRQ_VECTOR;
        end
        `CHK("irq fetch", 1'b1, hit)
        irqRequest <= 1'b0;
        masterClearN <= 1'b0;
        rcMode <= 1'b0;
        repeat (12) @(posedge ref_clk);
        `CHK("quarter off", 1'b0, quarterClockOut)
        `CHK("slot valid", 1'b0, execValid)
        masterClearN <= 1'b1;
        rcMode <= 1'b1;
        hit = 1'b0;
        for (int k = 0; k < 20 && !hit; k++)
        begin
            @(posedge ref_clk);
            hit = phaseOut.phaseOne;
        end
        `CHK("phase one after clear", 1'b1, hit)
        `CHK("first fetch", RESET_VECTOR, progAddr)
        watch <= 1'b1;
        runLoops(2, 1'b1);
        printVerdict();
    end
    // Cuts a hang short; the run needs well under 1000 clocks.
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        mismatches++;
        printVerdict();
    end
endmodule : qfp_pipeline_test

// *** verification/qfp_prog_rom.sv ***
// Program memory model holding a small loop with a flushed literal after a jump.
// Assumes a combinational answer for the address presented.
`timescale 1ns/1ps
module qfp_prog_rom
(
    input wire logic [qfp_pkg::PC_WIDTH-1:0] progAddr, // Fetch address.
    output logic [qfp_pkg::INSTR_WIDTH-1:0] progData // Word.
);
    import qfp_pkg::*;
    // Unlisted words read as no-operation, so a wild fetch stays harmless.
    always_comb
    begin
        case (progAddr)
            13'h0000: progData = 14'h2810; // Jump to the loop.
            13'h0004: progData = 14'h305A; // Interrupt entry.
            13'h0010: progData = 14'h303C; // Load literal.
            13'h0011: progData = 14'h00A1; // Store to 21h.
            13'h0012: progData = 14'h0722; // Add 22h into working register.
            13'h0013: progData = 14'h00A3; // Store to 23h.
            13'h0014: progData = 14'h2818; // Jump over the next word.
            13'h0015: progData = 14'h30FF; // Must be flushed.
            13'h0018: progData = 14'h00A4; // Store to 24h.
            13'h0019: progData = 14'h2810; // Back to the loop.
            default: progData = NOP_WORD;
        endcase
    end
endmodule : qfp_prog_rom
